// ===== dirq_pkg.sv
// package: constants and types for the interrupt and dma request logic
package dirq_pkg;
  // dma channel select encoding
  localparam logic dirq_chan_first = 1'h0;
  localparam logic dirq_chan_second = 1'h1;
  // values after reset
  localparam logic dirq_flag_reset = 1'h0;
  localparam logic [1:0] dirq_sync_reset = 2'h0;
  // index of each interrupt source
  localparam int dirq_src_conv = 0;
  localparam int dirq_src_tc = 1;
  localparam int dirq_src_stop = 2;
  localparam int dirq_src_cnt2 = 3;
  localparam int dirq_num_src = 4;
  typedef logic [dirq_num_src-1:0] dirq_src_t;
endpackage

// ===== dirq_if.sv
// interface: synchronised counter output and its rising-edge pulse
`timescale 1ns/1ps
interface dirq_edge_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// ===== dirq_edge_sync.sv
// module: two-stage synchroniser and rising-edge detector
`timescale 1ns/1ps
module dirq_edge_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // raw input
  input wire logic async_i,
  // synchronised output
  dirq_edge_if.src edge_o
);
  logic [1:0] sync;
  logic [1:0] next_sync;
  logic last;
  logic next_last;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_sync = {sync[0], async_i};
    next_last = sync[1];
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync <= dirq_pkg::dirq_sync_reset;
      last <= dirq_pkg::dirq_flag_reset;
    end else begin
      sync <= next_sync;
      last <= next_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign edge_o.level = sync[1];
  assign edge_o.rise = sync[1] & ~last;
endmodule // dirq_edge_sync

// ===== dirq_top.sv
// module: dma request and interrupt gating for the acquisition board
`timescale 1ns/1ps
module dirq_top (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // first command register bits
  input wire logic dma_request_enable_i,
  input wire logic double_buffer_dma_select_i,
  input wire logic conversion_irq_enable_i,
  input wire logic terminal_count_irq_enable_i,
  input wire logic acquisition_stop_irq_enable_i,
  // second command register bits
  input wire logic global_irq_enable_i,
  input wire logic counter2_edge_irq_enable_i,
  // board jumper: single-mode channel
  input wire logic single_channel_jumper_i,
  // conversion fifo and acquisition events
  input wire logic fifo_not_empty_i,
  input wire logic fifo_data_read_i,
  input wire logic acquisition_done_i,
  input wire logic fifo_overflow_i,
  input wire logic conversion_overrun_i,
  input wire logic counter2_output_i,
  // host dma and clear strobes
  input wire logic terminal_count_i,
  input wire logic terminal_count_clear_i,
  input wire logic terminal_count_irq_clear_i,
  input wire logic acquisition_clear_i,
  input wire logic counter2_edge_clear_reg_i,
  // dma requests
  output logic dma_request_first_o,
  output logic dma_request_second_o,
  // status flags
  output logic conversion_available_flag_o,
  output logic terminal_count_flag_o,
  output logic acquisition_stop_flag_o,
  output logic overflow_flag_o,
  output logic overrun_flag_o,
  output logic counter2_edge_flag_o,
  output logic dual_channel_active_o,
  // interrupt
  output logic irq_o
);
  dirq_edge_if cnt2_edge ();

  logic active_chan;
  logic next_active_chan;
  logic conv_pend;
  logic next_conv_pend;
  logic tc_flag;
  logic next_tc_flag;
  logic stop_flag;
  logic next_stop_flag;
  logic ovf_flag;
  logic next_ovf_flag;
  logic ovr_flag;
  logic next_ovr_flag;
  logic cnt2_flag;
  logic next_cnt2_flag;
  logic req_first;
  logic next_req_first;
  logic req_second;
  logic next_req_second;
  logic dual_mode;
  logic next_dual_mode;
  logic irq;
  logic next_irq;
  logic want_req;
  logic chan_sel;
  dirq_pkg::dirq_src_t pend;
  dirq_pkg::dirq_src_t enab;
  dirq_pkg::dirq_src_t hit;

  ////////////////////////////////////////////////////////////////////////////
  dirq_edge_sync u_cnt2_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i(counter2_output_i),
    .edge_o(cnt2_edge.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // dma mode and active channel
  always_comb begin
    next_dual_mode = dma_request_enable_i & double_buffer_dma_select_i;
    next_active_chan = active_chan;
    if (!next_dual_mode) begin
      next_active_chan = dirq_pkg::dirq_chan_first;
    end else if (terminal_count_i) begin
      next_active_chan = ~active_chan;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dual_mode <= dirq_pkg::dirq_flag_reset;
      active_chan <= dirq_pkg::dirq_chan_first;
    end else begin
      dual_mode <= next_dual_mode;
      active_chan <= next_active_chan;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma requests to the host
  always_comb begin
    want_req = dma_request_enable_i & fifo_not_empty_i;
    chan_sel = next_dual_mode ? next_active_chan : single_channel_jumper_i;
    next_req_first = want_req & (chan_sel == dirq_pkg::dirq_chan_first);
    next_req_second = want_req & (chan_sel == dirq_pkg::dirq_chan_second);
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_first <= dirq_pkg::dirq_flag_reset;
      req_second <= dirq_pkg::dirq_flag_reset;
    end else begin
      req_first <= next_req_first;
      req_second <= next_req_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion flag follows the fifo level
  always_comb begin
    next_conv_pend = fifo_not_empty_i;
    if ((fifo_data_read_i | acquisition_clear_i) & ~fifo_not_empty_i) begin
      next_conv_pend = dirq_pkg::dirq_flag_reset;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_pend <= dirq_pkg::dirq_flag_reset;
    end else begin
      conv_pend <= next_conv_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terminal count flag; a set in the clear cycle wins
  always_comb begin
    next_tc_flag = tc_flag;
    if (terminal_count_clear_i | terminal_count_irq_clear_i | acquisition_clear_i) begin
      next_tc_flag = dirq_pkg::dirq_flag_reset;
    end
    if (terminal_count_i) begin
      next_tc_flag = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tc_flag <= dirq_pkg::dirq_flag_reset;
    end else begin
      tc_flag <= next_tc_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition stop flag; a set in the clear cycle wins
  always_comb begin
    next_stop_flag = stop_flag;
    if (acquisition_clear_i) begin
      next_stop_flag = dirq_pkg::dirq_flag_reset;
    end
    if (acquisition_done_i | fifo_overflow_i | conversion_overrun_i) begin
      next_stop_flag = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_flag <= dirq_pkg::dirq_flag_reset;
    end else begin
      stop_flag <= next_stop_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo overflow error flag
  always_comb begin
    next_ovf_flag = ovf_flag;
    if (acquisition_clear_i) begin
      next_ovf_flag = dirq_pkg::dirq_flag_reset;
    end
    if (fifo_overflow_i) begin
      next_ovf_flag = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovf_flag <= dirq_pkg::dirq_flag_reset;
    end else begin
      ovf_flag <= next_ovf_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion overrun error flag
  always_comb begin
    next_ovr_flag = ovr_flag;
    if (acquisition_clear_i) begin
      next_ovr_flag = dirq_pkg::dirq_flag_reset;
    end
    if (conversion_overrun_i) begin
      next_ovr_flag = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ovr_flag <= dirq_pkg::dirq_flag_reset;
    end else begin
      ovr_flag <= next_ovr_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter 2 edge flag; a set in the clear cycle wins
  always_comb begin
    next_cnt2_flag = cnt2_flag;
    if (counter2_edge_clear_reg_i) begin
      next_cnt2_flag = dirq_pkg::dirq_flag_reset;
    end
    if (cnt2_edge.rise) begin
      next_cnt2_flag = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt2_flag <= dirq_pkg::dirq_flag_reset;
    end else begin
      cnt2_flag <= next_cnt2_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt gating per source
  always_comb begin
    pend[dirq_pkg::dirq_src_conv] = next_conv_pend;
    pend[dirq_pkg::dirq_src_tc] = next_tc_flag;
    pend[dirq_pkg::dirq_src_stop] = next_stop_flag;
    pend[dirq_pkg::dirq_src_cnt2] = next_cnt2_flag;
    enab[dirq_pkg::dirq_src_conv] = conversion_irq_enable_i;
    enab[dirq_pkg::dirq_src_tc] = dma_request_enable_i & terminal_count_irq_enable_i;
    enab[dirq_pkg::dirq_src_stop] = acquisition_stop_irq_enable_i;
    enab[dirq_pkg::dirq_src_cnt2] = counter2_edge_irq_enable_i;
  end

  for (genvar i = 0; i < dirq_pkg::dirq_num_src; i++) begin : g_src
    assign hit[i] = pend[i] & enab[i];
  end

  always_comb begin
    next_irq = global_irq_enable_i & (|hit);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq <= dirq_pkg::dirq_flag_reset;
    end else begin
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign dma_request_first_o = req_first;
  assign dma_request_second_o = req_second;
  assign conversion_available_flag_o = conv_pend;
  assign terminal_count_flag_o = tc_flag;
  assign acquisition_stop_flag_o = stop_flag;
  assign overflow_flag_o = ovf_flag;
  assign overrun_flag_o = ovr_flag;
  assign counter2_edge_flag_o = cnt2_flag;
  assign dual_channel_active_o = dual_mode;
  assign irq_o = irq;
endmodule // dirq_top

// ===== dirq_top_props.sv
// checker: timing relations of the request and flag outputs
`timescale 1ns/1ps
module dirq_top_props (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // configuration
  input wire logic dma_request_enable_i,
  input wire logic double_buffer_dma_select_i,
  input wire logic single_channel_jumper_i,
  // events and strobes
  input wire logic fifo_not_empty_i,
  input wire logic terminal_count_i,
  input wire logic terminal_count_clear_i,
  input wire logic acquisition_clear_i,
  input wire logic acquisition_done_i,
  input wire logic fifo_overflow_i,
  input wire logic conversion_overrun_i,
  input wire logic counter2_output_i,
  // watched outputs
  input wire logic dma_request_first_o,
  input wire logic dma_request_second_o,
  input wire logic terminal_count_flag_o,
  input wire logic acquisition_stop_flag_o,
  input wire logic overflow_flag_o,
  input wire logic overrun_flag_o,
  input wire logic counter2_edge_flag_o
);
  logic single;
  logic dgo;
  logic err;
  assign single = dma_request_enable_i && !double_buffer_dma_select_i && fifo_not_empty_i;
  assign dgo = dma_request_enable_i && double_buffer_dma_select_i && fifo_not_empty_i;
  assign err = fifo_overflow_i || conversion_overrun_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_off; !dma_request_enable_i |=> !(dma_request_first_o || dma_request_second_o); endproperty
  a_off: assert property (p_off) else $error("request while disabled");
  property p_one; single |=> dma_request_first_o != dma_request_second_o
    && dma_request_second_o == $past(single_channel_jumper_i); endproperty
  a_one: assert property (p_one) else $error("single channel wrong");
  property p_swap; dgo && terminal_count_i && $past(dgo) && !$past(terminal_count_i)
    |=> dma_request_second_o == $past(dma_request_first_o); endproperty
  a_swap: assert property (p_swap) else $error("no channel swap");
  property p_tc; terminal_count_i |=> terminal_count_flag_o; endproperty
  a_tc: assert property (p_tc) else $error("count flag not set");
  property p_tcclr; (terminal_count_clear_i || acquisition_clear_i) && !terminal_count_i
    |=> !terminal_count_flag_o; endproperty
  a_tcclr: assert property (p_tcclr) else $error("count flag not cleared");
  property p_stop; acquisition_done_i |=> acquisition_stop_flag_o; endproperty
  a_stop: assert property (p_stop) else $error("stop flag not set");
  property p_err; err |=> acquisition_stop_flag_o && (overflow_flag_o || overrun_flag_o);
  endproperty
  a_err: assert property (p_err) else $error("error stop not shown");
  property p_acq; acquisition_clear_i && !(err || acquisition_done_i)
    |=> !(acquisition_stop_flag_o || overflow_flag_o || overrun_flag_o); endproperty
  a_acq: assert property (p_acq) else $error("stop flags not cleared");
  property p_c2; $rose(counter2_output_i) |-> ##[1:4] counter2_edge_flag_o; endproperty
  a_c2: assert property (p_c2) else $error("counter edge missed");
endmodule // dirq_top_props
bind dirq_top dirq_top_props props_u (.*);

// ===== dirq_dma_host.sv
// partner: dma controller and conversion fifo facing the request logic
`timescale 1ns/1ps
module dirq_dma_host #(
  parameter int TC_LEN = 2
) (
  // clock
  input wire logic clk_sys_i,
  // request and fifo control
  input wire logic req_i,
  input wire logic push_i,
  input wire logic flush_i,
  input wire logic stall_i,
  input wire logic slow_i,
  // fifo state and dma strobes
  output logic not_empty_o,
  output logic read_o,
  output logic tc_o
);
  int fill = 0;
  int wait_c = 0;
  int count = 0;
  logic take;
  logic read_q = 1'h0;
  logic tc_q = 1'h0;
  assign not_empty_o = fill != 0;
  assign read_o = read_q;
  assign tc_o = tc_q;
  assign take = wait_c == 0 && req_i && !stall_i && fill != 0;
  always @(posedge clk_sys_i) begin
    read_q <= take;
    tc_q <= take && count % TC_LEN == TC_LEN - 1;
    count <= count + int'(take);
    wait_c <= take ? (slow_i ? 6 : 2) : (wait_c > 0 ? wait_c - 1 : 0);
    // acquisition clear empties the fifo
    fill <= flush_i ? 0 : fill + int'(push_i) - int'(take);
  end
endmodule // dirq_dma_host

// ===== dirq_top_bench.sv
// testbench: request and interrupt logic against a dma host model
`timescale 1ns/1ps
module dirq_top_bench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [6:0] cfg = 7'h00;
  logic [6:0] strb = 7'h00;
  logic jumper = 1'b0, c2 = 1'b0, push = 1'b0, stall = 1'b1, slow = 1'b0;
  logic req1, req2, ne, rd, tc, conv, tcf, stop, ovf, ovr, c2f, dual, irq;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  dirq_dma_host #(.TC_LEN(2)) host_u (.clk_sys_i(clk_sys_i), .req_i(req1 | req2),
    .push_i(push), .flush_i(strb[2]), .stall_i(stall), .slow_i(slow), .not_empty_o(ne),
    .read_o(rd), .tc_o(tc));
  dirq_top dut_u (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .dma_request_enable_i(cfg[6]),
    .double_buffer_dma_select_i(cfg[5]), .conversion_irq_enable_i(cfg[4]),
    .terminal_count_irq_enable_i(cfg[3]), .acquisition_stop_irq_enable_i(cfg[2]),
    .global_irq_enable_i(cfg[1]), .counter2_edge_irq_enable_i(cfg[0]),
    .single_channel_jumper_i(jumper), .fifo_not_empty_i(ne), .fifo_data_read_i(rd),
    .acquisition_done_i(strb[4]), .fifo_overflow_i(strb[5]), .conversion_overrun_i(strb[6]),
    .counter2_output_i(c2), .terminal_count_i(tc), .terminal_count_clear_i(strb[0]),
    .terminal_count_irq_clear_i(strb[1]), .acquisition_clear_i(strb[2]),
    .counter2_edge_clear_reg_i(strb[3]), .dma_request_first_o(req1),
    .dma_request_second_o(req2), .conversion_available_flag_o(conv),
    .terminal_count_flag_o(tcf), .acquisition_stop_flag_o(stop), .overflow_flag_o(ovf),
    .overrun_flag_o(ovr), .counter2_edge_flag_o(c2f), .dual_channel_active_o(dual),
    .irq_o(irq));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic hit(input int i);
    strb[i] = 1'b1;
    tick(1);
    strb[i] = 1'b0;
  endtask
  task automatic pushn(input int n);
    push = 1'b1;
    tick(n);
    push = 1'b0;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    tick(20);
    sys_rst_i = 1'b0;
    tick(3);
    // single channel, fifo held by stalled host
    pushn(1);
    tick(2);
    chk("req off", 1'b0, req1 | req2);
    for (int j = 0; j < 2; j++) begin
      jumper = j[0];
      cfg = 7'h52;
      tick(2);
      chk("req first", !j[0], req1);
      chk("req second", j[0], req2);
      chk("dual off", 1'b0, dual);
      chk("conv irq", 1'b1, irq);
    end
    cfg = 7'h50;
    tick(2);
    chk("gated irq", 1'b0, irq);
    cfg = 7'h52;
    stall = 1'b0;
    tick(6);
    chk("conv flag", 1'b0, conv);
    chk("conv irq end", 1'b0, irq);
    // dual channel with count clears
    stall = 1'b1;
    pushn(1);
    tick(2);
    chk("conv set", 1'b1, conv);
    hit(2);
    tick(1);
    chk("conv acq clr", 1'b0, conv);
    chk("conv acq irq", 1'b0, irq);
    cfg = 7'h6a;
    for (int k = 0; k < 4; k++) begin
      slow = k[0];
      pushn(2);
      tick(2);
      chk("dual", 1'b1, dual);
      chk("dual first", !k[0], req1);
      chk("dual second", k[0], req2);
      stall = 1'b0;
      tick(16);
      stall = 1'b1;
      chk("tc flag", 1'b1, tcf);
      chk("tc irq", 1'b1, irq);
      if (k == 3) begin
        cfg = 7'h2a;
        tick(1);
        chk("tc irq dma off", 1'b0, irq);
        chk("tc flag kept", 1'b1, tcf);
      end
      hit(k % 3);
      chk("tc irq clr", 1'b0, irq);
      if (k != 1) chk("tc flag clr", 1'b0, tcf);
    end
    // acquisition end, normal then error
    cfg = 7'h06;
    hit(4);
    chk("stop irq", 1'b1, stop & irq);
    chk("no err", 1'b0, ovf | ovr);
    hit(2);
    chk("stop clr", 1'b0, stop);
    hit(5);
    hit(6);
    chk("err", 1'b1, ovf & ovr & stop);
    hit(2);
    chk("err clr", 1'b0, ovf | ovr | stop | irq);
    // counter output edge
    cfg = 7'h03;
    c2 = 1'b1;
    tick(5);
    chk("c2 irq", 1'b1, c2f & irq);
    cfg = 7'h01;
    tick(1);
    chk("c2 gated", 1'b0, irq);
    cfg = 7'h03;
    hit(3);
    tick(4);
    chk("c2 clr", 1'b0, c2f | irq);
    c2 = 1'b0;
    stop_test();
  end
endmodule // dirq_top_bench
